// *** verilog/ekr_params.svh ***
// ekr_params.svh: register map, field positions, reset values and timing of the key block
// assumes inclusion by bare name from every design file that needs a figure
`ifndef EKR_PARAMS_SVH
`define EKR_PARAMS_SVH

// word indices, byte address is four times the index
`define EKR_IDX_CMD    6'h00
`define EKR_IDX_EVT    6'h01
`define EKR_IDX_CFG    6'h02
`define EKR_IDX_STAT   6'h03
`define EKR_IDX_RAND   6'h04
`define EKR_IDX_ESEL   6'h05
`define EKR_IDX_EIN    6'h06
`define EKR_IDX_EOUT   6'h07
`define EKR_IDX_OPND   3'h1
// command word fields
`define EKR_CMD_OP     2:0
`define EKR_CMD_INONLY 3
`define EKR_CMD_NOSEED 4
`define EKR_CMD_SLOT   8:5
`define EKR_CMD_VONLY  9
`define EKR_CMD_FAIL   10
`define EKR_CMD_COPYOK 11
// event word fields
`define EKR_EVT_SLEEP  0
`define EKR_EVT_BROWN  1
`define EKR_EVT_WDOG   2
`define EKR_EVT_TAMPER 3
`define EKR_EVT_IDLE   4
`define EKR_EVT_WAKE   5
// key geometry
`define EKR_KEY_WORDS  8
`define EKR_LAST_WORD  3'h7
// random source constants
`define EKR_TEST_WORD  32'h0000ffff
`define EKR_SEED_RST   32'h5a5a0001
`define EKR_LFSR_RST   32'h00000001
`define EKR_LFSR_TAPS  32'h80200003
// timing
`define EKR_CLK_KHZ    40000
`define EKR_WDOG_MS    1300
`endif

// *** verilog/ekr_pkg.sv ***
// ekr_pkg: types shared by the key block modules
// assumes nothing beyond a SystemVerilog compiler
package ekr_pkg;
	typedef logic [31:0] ekr_word_t;
	// command codes carried in the command word
	typedef enum logic [2:0] {
		EKR_OP_NONE   = 3'b000,
		EKR_OP_NONCE  = 3'b001,
		EKR_OP_DIGEST_GENERATE_CMD = 3'b010,
		EKR_OP_RANDOM = 3'b011,
		EKR_OP_OTHER  = 3'b100,
		EKR_OP_VERIFY = 3'b101,
		EKR_OP_CRCERR = 3'b110,
		EKR_OP_RSVD   = 3'b111
	} ekr_op_t;
	// key fill sequencer
	typedef enum logic [1:0] {
		EKR_S_IDLE = 2'b00,
		EKR_S_FILL = 2'b01
	} ekr_seq_t;
endpackage

// *** verilog/ekr_ifs.sv ***
// ekr_ifs: carriers between the controller, the key store and the random source
// assumes all parties run on one clock
interface ekr_key_if;
	logic             wr_en;
	logic [2:0]       wr_idx;
	ekr_pkg::ekr_word_t wr_word;
	logic             meta_en;
	logic             src_in;
	logic             gen_in;
	logic             chk_in;
	logic [3:0]       slot_in;
	logic             inval;
	logic             wipe;
	logic [2:0]       rd_idx;
	ekr_pkg::ekr_word_t rd_word;
	logic             valid;
	logic             src;
	logic             gen;
	logic             chk;
	logic [3:0]       slot;
	modport store(input wr_en, wr_idx, wr_word, meta_en, src_in, gen_in, chk_in, slot_in, inval, wipe, rd_idx,
		output rd_word, valid, src, gen, chk, slot);
	modport ctrl(output wr_en, wr_idx, wr_word, meta_en, src_in, gen_in, chk_in, slot_in, inval, wipe, rd_idx,
		input rd_word, valid, src, gen, chk, slot);
endinterface

interface ekr_rng_if;
	logic             next;
	logic             lock;
	logic             no_seed;
	logic             wipe;
	ekr_pkg::ekr_word_t word;
	logic             seed_ok;
	modport gen(input next, lock, no_seed, wipe, output word, seed_ok);
	modport ctrl(output next, lock, no_seed, wipe, input word, seed_ok);
endinterface

// *** verilog/ekr_key_store.sv ***
// ekr_key_store: the 256-bit ephemeral key and its metadata flags
// assumes the controller never raises inval and meta_en in one cycle except by design (set wins)
`include "ekr_params.svh"
module ekr_key_store
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// controller side
	ekr_key_if.store  k
);
	import ekr_pkg::*;

	ekr_word_t  key_reg [`EKR_KEY_WORDS];
	logic       valid_reg;
	logic       src_reg;
	logic       gen_reg;
	logic       chk_reg;
	logic [3:0] slot_reg;

	// key words, wiped on sleep, kept across idle
	always_ff @(posedge clk_i)
	begin
		if (rst_i || k.wipe)
		begin
			for (int i = 0; i < `EKR_KEY_WORDS; i++)
				key_reg[i] <= '0;
		end
		else if (k.wr_en)
			key_reg[k.wr_idx] <= k.wr_word;
	end

	// valid flag, a completed load wins over a same-cycle clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i || k.wipe)
			valid_reg <= 1'b0;
		else if (k.meta_en)
			valid_reg <= 1'b1;
		else if (k.inval)
			valid_reg <= 1'b0;
	end

	// metadata taken with the last key word
	always_ff @(posedge clk_i)
	begin
		if (rst_i || k.wipe)
		begin
			src_reg  <= 1'b0;
			gen_reg  <= 1'b0;
			chk_reg  <= 1'b0;
			slot_reg <= '0;
		end
		else if (k.meta_en)
		begin
			src_reg  <= k.src_in;
			gen_reg  <= k.gen_in;
			chk_reg  <= k.chk_in;
			slot_reg <= k.slot_in;
		end
	end

	// internal read port only, never reaches the bus as plain data
	assign k.rd_word = key_reg[k.rd_idx];
	assign k.valid   = valid_reg;
	assign k.src     = src_reg;
	assign k.gen     = gen_reg;
	assign k.chk     = chk_reg;
	assign k.slot    = k.gen ? slot_reg : 4'h0;
endmodule

// *** verilog/ekr_rng.sv ***
// ekr_rng: random word source, entropy stand-in mixed with a held seed
// assumes next pulses one cycle per word taken
`include "ekr_params.svh"
module ekr_rng
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// controller side
	ekr_rng_if.gen    r
);
	import ekr_pkg::*;

	ekr_word_t lfsr_reg;
	ekr_word_t nv_seed_reg;
	ekr_word_t seed_reg;
	logic      seed_ok_reg;

	// free-running entropy stand-in
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lfsr_reg <= `EKR_LFSR_RST;
		else
			lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `EKR_LFSR_TAPS) : (lfsr_reg >> 1);
	end

	// nonvolatile seed, advanced once per wake unless suppressed
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			nv_seed_reg <= `EKR_SEED_RST;
		else if (r.next && !seed_ok_reg && !r.no_seed)
			nv_seed_reg <= nv_seed_reg ^ lfsr_reg;
	end

	// volatile copy of the seed, lost on sleep
	always_ff @(posedge clk_i)
	begin
		if (rst_i || r.wipe)
		begin
			seed_reg    <= '0;
			seed_ok_reg <= 1'b0;
		end
		else if (r.next && !seed_ok_reg)
		begin
			seed_reg    <= r.no_seed ? nv_seed_reg : (nv_seed_reg ^ lfsr_reg);
			seed_ok_reg <= 1'b1;
		end
		else if (r.next)
			seed_reg <= {seed_reg[30:0], seed_reg[31]} ^ lfsr_reg;
	end

	// test pattern before the configuration lock, seed itself never leaves
	assign r.word    = r.lock ? (lfsr_reg ^ seed_reg) : `EKR_TEST_WORD;
	assign r.seed_ok = seed_ok_reg;
endmodule

// *** verilog/ekr_top.sv ***
// ekr_top: ephemeral key register, its flags and the random source behind a wishbone slave
// assumes a classic wishbone master on clk_i and a synchronous active-high reset at power-up
// Operation
// - sleep or power loss invalidates all volatile memory including the key; sleep keeps the protected-data word, its selector and the error flags
// - key holds 256 bits loaded by challenge-seed or digest-generate
// - key value never leaves the device on any interface
// - key encrypts protected data and feeds authentication and digest commands
// - four-bit slot index records the slot used by digest-generate
// - randomness source flag: 0 internal random, 1 input seed only
// - slot-derived flag marks slot use; slot index ignored when clear
// - verify-only flag set only when a verify-restricted key was used
// - valid flag is 1 when key usable, 0 otherwise
// - valid cleared on power-up, sleep, brown-out, watchdog, tamper; idle keeps key
// - any other command clears valid whether it succeeds or not
// - verify command keeps valid only after a successful copy
// - checksum-rejected commands leave valid unchanged
// - errors in challenge-seed or digest-generate clear valid
// - each load overwrites the previous key whatever made it
// - challenge-seed mixes random words with host input into the key
// - random command returns data without touching key or flags
// - before configuration lock the source gives ff ff 00 00 repeated
// - encrypted access only with a key built over internal randomness
// - random words come from entropy plus a seed that is never readable
// - stored seed updated once per wake, held volatile after
// - a mode bit suppresses the stored seed update
// - watchdog forces sleep after a fixed interval regardless of activity
`include "ekr_params.svh"
module ekr_top
#(
	parameter int unsigned WDOG_CYCLES = `EKR_WDOG_MS * `EKR_CLK_KHZ
)
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire ekr_pkg::ekr_word_t wb_dat_i,
	output ekr_pkg::ekr_word_t      wb_dat_o,
	output logic                   wb_ack_o,
	// device state
	output logic                   asleep_o,
	output logic                   key_valid_o
);
	import ekr_pkg::*;

	// byte-lane merge for partial writes
	function automatic ekr_word_t merge(input ekr_word_t old_w, input ekr_word_t new_w, input logic [3:0] sel);
		ekr_word_t res;
		res = old_w;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				res[b*8 +: 8] = new_w[b*8 +: 8];
		return res;
	endfunction

	ekr_key_if k_if();
	ekr_rng_if r_if();

	ekr_word_t  dat_reg;
	logic       ack_reg;
	logic       asleep_reg;
	ekr_op_t    op_reg;
	logic       inonly_reg;
	logic       nseed_reg;
	logic [3:0] slot_reg;
	logic       vonly_reg;
	logic       prev_src_reg;
	ekr_seq_t   seq_reg;
	logic [2:0] cnt_reg;
	logic       rand_pend_reg;
	ekr_word_t  rand_reg;
	logic       err_reg;
	logic       denied_reg;
	logic       lock_reg;
	logic [2:0] esel_reg;
	ekr_word_t  ein_reg;
	ekr_word_t  opnd_reg [`EKR_KEY_WORDS];
	logic [31:0] wdog_reg;

	logic [5:0] idx;
	logic       req;
	logic       wr;
	logic       rd;
	logic       go;
	ekr_op_t    op_in;
	logic       fail_in;
	logic       load_ok;
	logic       sleep_ev;
	logic       wake_ev;
	logic       idle_ev;
	logic       wdog_exp;
	logic       enc_ok;
	ekr_word_t  status_w;

	// bus request decode, one answer per request
	assign idx = wb_adr_i[7:2];
	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr  = req && wb_we_i;
	assign rd  = req && !wb_we_i;

	// command acceptance, ignored while asleep or busy
	assign op_in   = ekr_op_t'(wb_dat_i[`EKR_CMD_OP]);
	assign fail_in = wb_dat_i[`EKR_CMD_FAIL];
	assign go      = wr && (idx == `EKR_IDX_CMD) && !asleep_reg && (seq_reg == EKR_S_IDLE) && !rand_pend_reg;
	assign load_ok = !fail_in && ((op_in == EKR_OP_NONCE) || ((op_in == EKR_OP_DIGEST_GENERATE_CMD) && k_if.valid));

	// power events, watchdog expiry acts as a sleep
	assign wdog_exp = !asleep_reg && (wdog_reg == WDOG_CYCLES - 1);
	assign sleep_ev = (wr && (idx == `EKR_IDX_EVT) && (wb_dat_i[`EKR_EVT_SLEEP] || wb_dat_i[`EKR_EVT_BROWN]
		|| wb_dat_i[`EKR_EVT_WDOG] || wb_dat_i[`EKR_EVT_TAMPER])) || wdog_exp;
	assign wake_ev  = wr && (idx == `EKR_IDX_EVT) && wb_dat_i[`EKR_EVT_WAKE] && asleep_reg;
	assign idle_ev  = wr && (idx == `EKR_IDX_EVT) && wb_dat_i[`EKR_EVT_IDLE];

	// encrypted access needs a valid key built over internal randomness
	assign enc_ok = k_if.valid && !k_if.src;

	// status word
	always_comb
	begin
		status_w     = '0;
		status_w[0]  = k_if.valid;
		status_w[1]  = k_if.src;
		status_w[2]  = k_if.gen;
		status_w[3]  = k_if.chk;
		status_w[7:4] = k_if.slot;
		status_w[8]  = lock_reg;
		status_w[9]  = asleep_reg;
		status_w[10] = r_if.seed_ok;
		status_w[11] = (seq_reg != EKR_S_IDLE) || rand_pend_reg;
		status_w[12] = err_reg;
		status_w[13] = denied_reg;
	end

	// key store drive: fill words, metadata with the last word
	always_comb
	begin
		k_if.wr_en   = (seq_reg == EKR_S_FILL);
		k_if.wr_idx  = cnt_reg;
		k_if.wr_word = opnd_reg[cnt_reg];
		if ((op_reg == EKR_OP_NONCE) && !inonly_reg)
			k_if.wr_word = opnd_reg[cnt_reg] ^ r_if.word;
		k_if.meta_en = (seq_reg == EKR_S_FILL) && (cnt_reg == `EKR_LAST_WORD);
		k_if.src_in  = (op_reg == EKR_OP_NONCE) ? inonly_reg : prev_src_reg;
		k_if.gen_in  = (op_reg == EKR_OP_DIGEST_GENERATE_CMD);
		k_if.chk_in  = (op_reg == EKR_OP_DIGEST_GENERATE_CMD) && vonly_reg;
		k_if.slot_in = slot_reg;
		k_if.wipe    = sleep_ev;
		k_if.rd_idx  = esel_reg;
		k_if.inval   = 1'b0;
		if (go)
		begin
			unique case (op_in)
				EKR_OP_NONE, EKR_OP_CRCERR, EKR_OP_RANDOM: k_if.inval = 1'b0;
				EKR_OP_NONCE, EKR_OP_DIGEST_GENERATE_CMD: k_if.inval = 1'b1;
				EKR_OP_VERIFY: k_if.inval = !wb_dat_i[`EKR_CMD_COPYOK];
				EKR_OP_OTHER, EKR_OP_RSVD: k_if.inval = 1'b1;
			endcase
		end
	end

	// random source drive
	always_comb
	begin
		r_if.next    = rand_pend_reg || ((seq_reg == EKR_S_FILL) && (op_reg == EKR_OP_NONCE) && !inonly_reg);
		r_if.lock    = lock_reg;
		r_if.no_seed = nseed_reg;
		r_if.wipe    = sleep_ev;
	end

	ekr_key_store u_key
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.k     (k_if)
	);

	ekr_rng u_rng
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.r     (r_if)
	);

	// bus answer one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end

	// read data; operand words, seed and key read as zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_reg <= '0;
		else if (rd)
		begin
			case (idx)
				`EKR_IDX_CFG:  dat_reg <= {31'h0, lock_reg};
				`EKR_IDX_STAT: dat_reg <= status_w;
				`EKR_IDX_RAND: dat_reg <= rand_reg;
				`EKR_IDX_ESEL: dat_reg <= {29'h0, esel_reg};
				`EKR_IDX_EIN:  dat_reg <= ein_reg;
				`EKR_IDX_EOUT: dat_reg <= enc_ok ? (ein_reg ^ k_if.rd_word) : '0;
				default:       dat_reg <= '0;
			endcase
		end
		else
			dat_reg <= '0;
	end

	// sleep state and watchdog, power-up leaves the device awake
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			asleep_reg <= 1'b0;
		else if (sleep_ev)
			asleep_reg <= 1'b1;
		else if (wake_ev)
			asleep_reg <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || asleep_reg || idle_ev)
			wdog_reg <= '0;
		else
			wdog_reg <= wdog_reg + 32'h1;
	end

	// command fields held for the fill and the random fetch
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			op_reg       <= EKR_OP_NONE;
			inonly_reg   <= 1'b0;
			nseed_reg    <= 1'b0;
			slot_reg     <= '0;
			vonly_reg    <= 1'b0;
			prev_src_reg <= 1'b0;
		end
		else if (go)
		begin
			op_reg       <= op_in;
			inonly_reg   <= wb_dat_i[`EKR_CMD_INONLY];
			nseed_reg    <= wb_dat_i[`EKR_CMD_NOSEED];
			slot_reg     <= wb_dat_i[`EKR_CMD_SLOT];
			vonly_reg    <= wb_dat_i[`EKR_CMD_VONLY];
			prev_src_reg <= k_if.src;
		end
	end

	// fill sequencer, eight words then back to idle; sleep aborts
	always_ff @(posedge clk_i)
	begin
		if (rst_i || sleep_ev)
		begin
			seq_reg <= EKR_S_IDLE;
			cnt_reg <= '0;
		end
		else
		begin
			unique case (seq_reg)
				EKR_S_IDLE:
				begin
					cnt_reg <= '0;
					if (go && load_ok)
						seq_reg <= EKR_S_FILL;
				end
				EKR_S_FILL:
				begin
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == `EKR_LAST_WORD)
						seq_reg <= EKR_S_IDLE;
				end
				default: seq_reg <= EKR_S_IDLE;
			endcase
		end
	end

	// random command: one word fetched the cycle after acceptance
	always_ff @(posedge clk_i)
	begin
		if (rst_i || sleep_ev)
			rand_pend_reg <= 1'b0;
		else
			rand_pend_reg <= go && (op_in == EKR_OP_RANDOM) && !fail_in;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || sleep_ev)
			rand_reg <= '0;
		else if (rand_pend_reg)
			rand_reg <= r_if.word;
	end

	// command error flag, set by a failed or premature command
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			err_reg <= 1'b0;
		else if (go && (op_in != EKR_OP_CRCERR))
			err_reg <= fail_in || ((op_in == EKR_OP_DIGEST_GENERATE_CMD) && !k_if.valid);
	end

	// configuration lock, one way
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lock_reg <= 1'b0;
		else if (wr && (idx == `EKR_IDX_CFG) && wb_sel_i[0] && wb_dat_i[0])
			lock_reg <= 1'b1;
	end

	// protected-data word and selector; a denied read sets a sticky flag
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			esel_reg <= '0;
			ein_reg  <= '0;
		end
		else
		begin
			if (wr && (idx == `EKR_IDX_ESEL) && wb_sel_i[0])
				esel_reg <= wb_dat_i[2:0];
			if (wr && (idx == `EKR_IDX_EIN))
				ein_reg <= merge(ein_reg, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			denied_reg <= 1'b0;
		else if (rd && (idx == `EKR_IDX_EOUT) && !enc_ok)
			denied_reg <= 1'b1;
		else if (wr && (idx == `EKR_IDX_ESEL))
			denied_reg <= 1'b0;
	end

	// host operand words: seed input or digest, cleared on sleep
	always_ff @(posedge clk_i)
	begin
		if (rst_i || sleep_ev)
		begin
			for (int i = 0; i < `EKR_KEY_WORDS; i++)
				opnd_reg[i] <= '0;
		end
		else if (wr && (idx[5:3] == `EKR_IDX_OPND))
			opnd_reg[idx[2:0]] <= merge(opnd_reg[idx[2:0]], wb_dat_i, wb_sel_i);
	end

	// outputs from flip-flops
	assign wb_dat_o    = dat_reg;
	assign wb_ack_o    = ack_reg;
	assign asleep_o    = asleep_reg;
	assign key_valid_o = k_if.valid;
endmodule

// *** tb/ekr_top_checker.sv ***
// ekr_top_checker: bus timing, key valid flag and watchdog checks on the top ports
// assumes a bind into every ekr_top; one clock, synchronous active-high reset
module ekr_top_checker
#(
	parameter int unsigned WDOG_CYCLES = 64
)
(
	// clock and reset
	input wire logic               clk_i,
	input wire logic               rst_i,
	// wishbone
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic [7:0]         wb_adr_i,
	input wire logic [3:0]         wb_sel_i,
	input wire ekr_pkg::ekr_word_t wb_dat_i,
	input wire ekr_pkg::ekr_word_t wb_dat_o,
	input wire logic               wb_ack_o,
	// device state
	input wire logic               asleep_o,
	input wire logic               key_valid_o
);
	import ekr_pkg::*;
	logic        tk;
	logic        cmd_go;
	logic        evt_go;
	logic [2:0]  op;
	logic [3:0]  fill_cnt;
	int unsigned awake_cnt;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// request taken, and commands the device will act on
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmd_go = tk && wb_we_i && wb_adr_i[7:2] == 6'h00 && !asleep_o && fill_cnt == 4'h0;
	assign evt_go = tk && wb_we_i && wb_adr_i[7:2] == 6'h01;
	assign op = wb_dat_i[2:0];
	// key fill in flight, so refused commands do not arm the checks
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (evt_go && wb_dat_i[3:0] != 4'h0))
			fill_cnt <= 4'h0;
		else if (cmd_go && (op == 3'h1 || op == 3'h2))
			fill_cnt <= 4'h8; // busy for the eight fill edges that follow acceptance
		else if (fill_cnt != 4'h0)
			fill_cnt <= fill_cnt - 4'h1;
	end
	// cycles awake since reset, idle or wake; activity does not restart it
	always_ff @(posedge clk_i)
	begin
		if (rst_i || asleep_o || (evt_go && wb_dat_i[5:4] != 2'h0))
			awake_cnt <= 0;
		else
			awake_cnt <= awake_cnt + 1;
	end
	sequence s_fill_go;
		cmd_go && !wb_dat_i[10] && (op == 3'h1 || (op == 3'h2 && key_valid_o));
	endsequence
	sequence s_fill_done;
		(!key_valid_o)[*8] ##1 key_valid_o; // valid is set by the eighth fill edge
	endsequence
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_time_a: assert property (tk |=> wb_ack_o)
		else $error("request not acknowledged in one cycle");
	dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data driven outside an answer");
	secret_read_a: assert property (tk && !wb_we_i && wb_adr_i[7:5] != 3'h0 |=> wb_dat_o == 32'h0)
		else $error("operand word readable");
	reset_state_a: assert property ($fell(rst_i) |-> !key_valid_o && !asleep_o && !wb_ack_o)
		else $error("state not cleared by reset");
	fill_load_a: assert property (s_fill_go |=> s_fill_done)
		else $error("key load timing or valid flag wrong");
	other_clear_a: assert property (cmd_go && (op == 3'h4 || op == 3'h7 || (op == 3'h5 && !wb_dat_i[11])) |-> ##[1:2] !key_valid_o)
		else $error("valid kept after a clearing command");
	keep_valid_a: assert property (cmd_go && key_valid_o && (op == 3'h3 || op == 3'h6 || (op == 3'h5 && wb_dat_i[11])) |=> key_valid_o[*3])
		else $error("valid lost on a keeping command");
	sleep_wipe_a: assert property (evt_go && wb_dat_i[3:0] != 4'h0 |=> asleep_o ##[0:1] !key_valid_o)
		else $error("sleep event did not sleep and wipe");
	idle_keep_a: assert property (evt_go && wb_dat_i == 32'h10 && key_valid_o && fill_cnt == 4'h0 |=> key_valid_o)
		else $error("idle lost the key");
	wdog_bound_a: assert property (!asleep_o |-> awake_cnt < WDOG_CYCLES + 4)
		else $error("watchdog did not force sleep");
endmodule

bind ekr_top ekr_top_checker #(.WDOG_CYCLES(WDOG_CYCLES)) u_ekr_top_checker (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .asleep_o(asleep_o), .key_valid_o(key_valid_o));

// *** tb/ekr_host_model.sv ***
// ekr_host_model: wishbone master standing in for the host that issues commands
// assumes a classic single-cycle slave on clk_i; the bench calls xfer
module ekr_host_model
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone master
	output logic                    wb_cyc_o,
	output logic                    wb_stb_o,
	output logic                    wb_we_o,
	output logic [7:0]              wb_adr_o,
	output logic [3:0]              wb_sel_o,
	output ekr_pkg::ekr_word_t      wb_dat_o,
	input  wire logic               wb_ack_i,
	input  wire ekr_pkg::ekr_word_t wb_dat_i
);
	import ekr_pkg::*;
	// bus idle at time zero
	initial
	begin
		{wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
	end
	// one classic cycle; released lines show the inverse so stale values never match
	task automatic xfer(input logic we, input logic [7:0] adr, input ekr_word_t dat);
		while (rst_i)
			@(posedge clk_i);
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hf;
		wb_dat_o <= dat;
		@(posedge clk_i);
		while (wb_ack_i !== 1'b1)
			@(posedge clk_i);
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= ~we;
		wb_adr_o <= ~adr;
		wb_sel_o <= 4'h0;
		wb_dat_o <= ~dat;
	endtask
endmodule

// *** tb/test_ekr_top.sv ***
// test_ekr_top: self-checking bench for the key block, reads checked through a queue
// assumes the host model drives the bus and the checker is bound in
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
	$display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module test_ekr_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ekr_pkg::*;
	localparam int unsigned WDOG = 400;
	typedef struct packed { ekr_word_t v; ekr_word_t m; } ekr_exp_t;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       wb_cyc, wb_stb, wb_we, wb_ack, asleep, key_valid;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	ekr_word_t  wb_dat_w, wb_dat_r, x;
	ekr_word_t  opnd [8];
	ekr_exp_t   exp_q [$];
	ekr_exp_t   e;
	int         bad_count = 0;
	int         comparisons = 0;
	int         cycles = 0;
	integer     seed = 83497;
	always #12.5 clk_i = ~clk_i;
	ekr_top #(.WDOG_CYCLES(WDOG)) u_ekr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
		.wb_ack_o(wb_ack), .asleep_o(asleep), .key_valid_o(key_valid));
	ekr_host_model u_ekr_host_model (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
		.wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w), .wb_ack_i(wb_ack),
		.wb_dat_i(wb_dat_r));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input ekr_word_t d);
		u_ekr_host_model.xfer(1'b1, a, d);
	endtask
	// note the masked expectation, then read
	task automatic rd(input logic [7:0] a, input ekr_word_t v, input ekr_word_t m);
		exp_q.push_back('{v & m, m});
		u_ekr_host_model.xfer(1'b0, a, 32'h0);
	endtask
	// idle first so the watchdog restarts, then the command and its fill time
	task automatic cmd(input ekr_word_t c);
		wr(8'h04, 32'h10);
		wr(8'h00, c);
		repeat (10) @(posedge clk_i);
	endtask
	task automatic load_opnd();
		for (int i = 0; i < 8; i++)
		begin
			opnd[i] = $random(seed);
			wr(8'h20 + 8'(4 * i), opnd[i]);
		end
	endtask
	// encrypt one word with key word k; a refused access reads zero
	task automatic eout(input int k, input ekr_word_t key, input logic ok);
		wr(8'h14, 32'(k));
		x = $random(seed);
		wr(8'h18, x);
		rd(8'h1c, ok ? x ^ key : 32'h0, 32'hffffffff);
	endtask
	// compare each read answer with the oldest note
	always @(posedge clk_i)
	begin
		if (!rst_i && wb_ack && !wb_we)
		begin
			e = exp_q.pop_front();
			`CHK(wb_dat_r & e.m, e.v)
		end
	end
	// hang guard
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			$display("ERROR %0t: timeout", $time);
			summarize();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h0c, 32'h0, 32'h3fff);
		load_opnd();
		cmd(32'h1);
		rd(8'h0c, 32'h1, 32'h1ff);
		eout(2, opnd[2] ^ 32'h0000ffff, 1'b1);
		cmd(32'h3);
		rd(8'h10, 32'h0000ffff, 32'hffffffff);
		rd(8'h10, 32'h0000ffff, 32'hffffffff);
		rd(8'h0c, 32'h1, 32'h1ff);
		load_opnd();
		cmd(32'h2a2);
		rd(8'h0c, 32'h5d, 32'h1ff);
		for (int k = 0; k < 8; k++)
			eout(k, opnd[k], 1'b1);
		wr(8'h04, 32'h10);
		rd(8'h0c, 32'h5d, 32'h1ff);
		cmd(32'h6);
		rd(8'h0c, 32'h5d, 32'h1ff);
		cmd(32'h805);
		rd(8'h0c, 32'h1, 32'h1);
		cmd(32'h5);
		rd(8'h0c, 32'h0, 32'h1);
		eout(0, 32'h0, 1'b0);
		rd(8'h0c, 32'h2000, 32'h2000);
		cmd(32'h2);
		rd(8'h0c, 32'h0, 32'h1);
		cmd(32'h1);
		cmd(32'h401);
		rd(8'h0c, 32'h0, 32'h1);
		cmd(32'h9);
		rd(8'h0c, 32'h3, 32'h1ff);
		cmd(32'h62);
		rd(8'h0c, 32'h37, 32'h1ff);
		eout(1, 32'h0, 1'b0);
		foreach (opnd[i])
			if (i < 2)
			begin
				cmd(32'h1);
				cmd(i == 0 ? 32'h4 : 32'h7);
				rd(8'h0c, 32'h0, 32'h1);
			end
		// a command written while the fill runs is ignored
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h4);
		repeat (10) @(posedge clk_i);
		rd(8'h0c, 32'h1, 32'h1);
		rd(8'h20, 32'h0, 32'hffffffff);
		rd(8'h40, 32'h0, 32'hffffffff);
		wr(8'h08, 32'h1);
		rd(8'h0c, 32'h100, 32'h100);
		for (int b = 0; b < 4; b++)
		begin
			cmd(32'h9);
			wr(8'h04, 32'h1 << b);
			rd(8'h0c, 32'h200, 32'h601);
			wr(8'h04, 32'h20);
		end
		cmd(32'h13);
		rd(8'h0c, 32'h400, 32'h400);
		cmd(32'h3);
		rd(8'h0c, 32'h400, 32'h400);
		wr(8'h04, 32'h10);
		repeat (WDOG + 20) @(posedge clk_i);
		rd(8'h0c, 32'h200, 32'h201);
		wr(8'h04, 32'h20);
		repeat (5) @(posedge clk_i);
		`CHK(exp_q.size(), 0)
		summarize();
	end
endmodule
